// ### src/rrit_top.sv
// rom, ram, two ports and interval timer behind the processor bus
// assumes bus signals come from logic on CORE_CLK; port pins are asynchronous
//
// Functional notes
// - read/write line high reads, low writes; acted on only when addressed
// - port b bit seven rests high, driven low for timer interrupt
// - data bus drivers off except during a read of this device
// - direction bit 0 makes pin input, 1 drives stored data bit
// - input pins idle high through weak pull-up
// - port read returns pins for inputs, latch bits for outputs
// - port latches change only on writes, never on reads
// - port b bits five and six are chip selects or pins by option
// - 64-byte ram, low six address bits, enabled by upper decode
// - timer write loads count; address bits 1..0 pick prescale
// - address bit 3 on timer access enables interrupt on pin
// - before expiry a timer read returns intervals remaining
// - interval after zero sets flag, counter reads all ones
// - after flag, counter decrements every clock
// - timer access after interrupt clears flag; coincident read does not
// - flag read returns flag on bit seven, zeros below
// - enabled interrupt with flag set drives port b bit seven low
// - reset clears ports and directions, floats bus, disables interrupt
// - address bit 2 picks timer or ports; bits 1..0 pick register
`timescale 1ns/1ps
module rrit_top
    import rrit_pkg::*;
#(
    parameter bit         CS_ONE_USED  = 1'b0,
    parameter bit         CS_ONE_LEVEL = 1'b0,
    parameter bit         CS_TWO_USED  = 1'b0,
    parameter bit         CS_TWO_LEVEL = 1'b0,
    parameter logic [3:0] RAM_CODE     = RAM_CODE_DEFAULT,
    parameter logic [3:0] IO_CODE      = IO_CODE_DEFAULT,
    parameter bit         IRQ_PULLUP   = 1'b1
) (
    // clock and reset
    input  wire logic [0:0]  CORE_CLK,
    input  wire logic        NRST,
    // processor bus
    input  wire logic [9:0]  ADDR,
    input  wire logic        REGION_SELECT,
    input  wire logic        READ_NOT_WRITE,
    input  wire logic [7:0]  CPU_DATA_BUS_IN,
    output logic      [7:0]  CPU_DATA_BUS_OUT,
    output logic             CPU_DATA_BUS_OE,
    // port a
    input  wire logic [7:0]  PORT_A_PINS_IN,
    output logic      [7:0]  PORT_A_PINS_OUT,
    output logic      [7:0]  PORT_A_PINS_OE,
    // port b
    input  wire logic [7:0]  PORT_B_PINS_IN,
    output logic      [7:0]  PORT_B_PINS_OUT,
    output logic      [7:0]  PORT_B_PINS_OE,
    output logic             PORT_B_BIT_SEVEN_PULLUP
);
    rrit_bus_req_type   req;
    rrit_pins_type      pa_pins;
    rrit_pins_type      pb_pins;
    rrit_tmr_state_type state;
    rrit_tmr_state_type next_state;

    logic       cs_one_ok;
    logic       cs_two_ok;
    logic       cs_ok;
    logic       rom_sel;
    logic       ram_sel;
    logic       io_sel;
    logic       tmr_sel;
    logic       reg_sel;
    logic       tmr_wr;
    logic       tmr_rd;
    logic       flag_rd;
    logic       tmr_acc;
    logic       ram_wr;
    logic       rd_any;
    logic       wr_pa_data;
    logic       wr_pa_dir;
    logic       wr_pb_data;
    logic       wr_pb_dir;
    logic       tick;
    logic       expire;
    logic       flag;
    logic       irq_en;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] pa_data;
    logic [7:0] pa_dir;
    logic [7:0] pa_view;
    logic [7:0] pb_data;
    logic [7:0] pb_dir;
    logic [7:0] pb_view;
    logic [7:0] reg_view;
    logic [7:0] tmr_view;
    logic [7:0] rom_data;
    logic [7:0] ram_data;
    logic [7:0] next_rd_data;
    logic [7:0] pb_hold_off;
    logic [7:0] pb_force_low;
    logic [7:0] ram [RAM_DEPTH];

    // mask contents stand in as a fixed pattern of the address
    function automatic logic [7:0] rom_byte(input logic [9:0] a);
        rom_byte = a[7:0] ^ {a[9:8], 6'h00};
    endfunction

    assign req = '{addr: ADDR, rs: REGION_SELECT, rd: READ_NOT_WRITE,
                   data: CPU_DATA_BUS_IN};

    // chip selects are processor address lines on this clock, so no sync
    // chip select option
    assign cs_one_ok = !CS_ONE_USED || (PORT_B_PINS_IN[CS_ONE_BIT] == CS_ONE_LEVEL);
    assign cs_two_ok = !CS_TWO_USED || (PORT_B_PINS_IN[CS_TWO_BIT] == CS_TWO_LEVEL);
    assign cs_ok     = cs_one_ok && cs_two_ok;

    assign rom_sel = cs_ok && req.rs;
    assign ram_sel = cs_ok && !req.rs && (req.addr[9:6] == RAM_CODE);
    assign io_sel  = cs_ok && !req.rs && (req.addr[9:6] == IO_CODE);

    assign tmr_sel = io_sel && req.addr[TIMER_SEL_BIT];
    assign reg_sel = io_sel && !req.addr[TIMER_SEL_BIT];

    assign tmr_wr  = tmr_sel && !req.rd;
    assign tmr_rd  = tmr_sel && req.rd && !req.addr[FLAG_SEL_BIT];
    assign flag_rd = tmr_sel && req.rd && req.addr[FLAG_SEL_BIT];
    assign tmr_acc = tmr_wr || tmr_rd;
    assign ram_wr  = ram_sel && !req.rd;
    assign rd_any  = req.rd && (rom_sel || ram_sel || io_sel);

    assign wr_pa_data = reg_sel && !req.rd && (req.addr[1:0] == SEL_PORT_A_DATA);
    assign wr_pa_dir  = reg_sel && !req.rd && (req.addr[1:0] == SEL_PORT_A_DIR);
    assign wr_pb_data = reg_sel && !req.rd && (req.addr[1:0] == SEL_PORT_B_DATA);
    assign wr_pb_dir  = reg_sel && !req.rd && (req.addr[1:0] == SEL_PORT_B_DIR);

    assign pb_hold_off = {1'b0, CS_ONE_USED, CS_TWO_USED, 5'h00};
    assign pb_force_low = {irq_en && flag, 7'h00};

    rrit_io_port u_port_a (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .wr_data   (wr_pa_data),
        .wr_dir    (wr_pa_dir),
        .wr_val    (req.data),
        .hold_off  (8'h00),
        .force_low (8'h00),
        .pins_in   (PORT_A_PINS_IN),
        .pins      (pa_pins),
        .data      (pa_data),
        .dir       (pa_dir),
        .view      (pa_view)
    );

    rrit_io_port u_port_b (
        .clk       (CORE_CLK),
        .nrst      (NRST),
        .wr_data   (wr_pb_data),
        .wr_dir    (wr_pb_dir),
        .wr_val    (req.data),
        .hold_off  (pb_hold_off),
        .force_low (pb_force_low),
        .pins_in   (PORT_B_PINS_IN),
        .pins      (pb_pins),
        .data      (pb_data),
        .dir       (pb_dir),
        .view      (pb_view)
    );

    assign PORT_A_PINS_OUT = pa_pins.out;
    assign PORT_A_PINS_OE  = pa_pins.oe;
    assign PORT_B_PINS_OUT = pb_pins.out;
    assign PORT_B_PINS_OE  = pb_pins.oe;

    rrit_prescale u_prescale (
        .clk     (CORE_CLK),
        .nrst    (NRST),
        .restart (tmr_wr),
        .rate_in (req.addr[1:0]),
        .tick    (tick)
    );

    assign flag   = (state == TMR_EXPIRED);
    assign expire = (state == TMR_COUNTING) && tick && (count == 8'h00);

    assign next_count = tmr_wr ? req.data :
                        (flag || tick) ? count - 8'h01 : count;

    always_comb begin
        next_state = state;
        unique case (state)
            TMR_COUNTING: next_state = (expire && !tmr_wr) ? TMR_EXPIRED : TMR_COUNTING;
            TMR_EXPIRED:  next_state = tmr_acc ? TMR_COUNTING : TMR_EXPIRED;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state  <= TMR_COUNTING;
            count  <= COUNT_RESET;
            irq_en <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            if (tmr_acc) irq_en <= req.addr[IRQ_EN_BIT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (ram_wr) ram[req.addr[RAM_ADDR_W-1:0]] <= req.data;
    end

    assign ram_data = ram[req.addr[RAM_ADDR_W-1:0]];
    assign rom_data = rom_byte(req.addr);

    assign reg_view = (req.addr[1:0] == SEL_PORT_A_DATA) ? pa_view :
                      (req.addr[1:0] == SEL_PORT_A_DIR)  ? pa_dir  :
                      (req.addr[1:0] == SEL_PORT_B_DATA) ? pb_view : pb_dir;
    assign tmr_view = req.addr[FLAG_SEL_BIT] ? {flag, 7'h00} : count;

    assign next_rd_data = rom_sel ? rom_data :
                          ram_sel ? ram_data :
                          req.addr[TIMER_SEL_BIT] ? tmr_view : reg_view;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            CPU_DATA_BUS_OE  <= 1'b0;
            CPU_DATA_BUS_OUT <= BUS_DATA_RESET;
        end else begin
            CPU_DATA_BUS_OE  <= rd_any;
            CPU_DATA_BUS_OUT <= rd_any ? next_rd_data : BUS_DATA_RESET;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) PORT_B_BIT_SEVEN_PULLUP <= IRQ_PULLUP;
        else PORT_B_BIT_SEVEN_PULLUP <= IRQ_PULLUP;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_rate8_load;
        tmr_wr && (req.addr[1:0] == RATE_8T);
    endsequence

    sequence s_quiet;
        !tmr_acc;
    endsequence

    a_bus_float_idle: assert property (
        CPU_DATA_BUS_OE |-> $past(rd_any))
        else $error("data bus driven without a read");

    a_port_read_mix: assert property (
        (reg_sel && req.rd && req.addr[1:0] == SEL_PORT_A_DATA)
        |=> CPU_DATA_BUS_OUT == (($past(pa_dir) & $past(pa_data))
                                 | (~$past(pa_dir) & $past(pa_view))))
        else $error("port a read mixes pins and latch wrongly");

    a_port_hold_read: assert property (
        (reg_sel && req.rd) |=> $stable(pa_data) && $stable(pb_data))
        else $error("port latch changed on a read");

    a_timer_load: assert property (
        tmr_wr |=> count == $past(req.data))
        else $error("timer write did not load count");

    a_first_interval: assert property (
        s_rate8_load ##1 s_quiet |=> count == $past(count) - 8'h01)
        else $error("prescaler not restarted by timer write");

    a_irq_enable_sample: assert property (
        tmr_acc |=> irq_en == $past(req.addr[IRQ_EN_BIT]))
        else $error("interrupt enable not taken from address bit 3");

    a_flag_set_wrap: assert property (
        $rose(flag) |-> count == 8'hff && $past(count) == 8'h00)
        else $error("flag set without wrap to all ones");

    a_fast_decrement: assert property (
        (flag && !tmr_wr) [*2] |=> count == $past(count, 2) - 8'h02)
        else $error("counter not decrementing every clock after flag");

    a_flag_clear_access: assert property (
        (flag && tmr_acc) |=> !flag)
        else $error("timer access after interrupt left flag set");

    a_flag_read_form: assert property (
        flag_rd |=> CPU_DATA_BUS_OUT == {$past(flag), 7'h00})
        else $error("flag read has wrong format");

    a_irq_pin_low: assert property (
        (irq_en && flag) |=> !PORT_B_PINS_OUT[IRQ_PIN_BIT] && PORT_B_PINS_OE[IRQ_PIN_BIT])
        else $error("enabled interrupt did not pull pin low");

    a_input_idle_high: assert property (
        (pa_dir == 8'h00) [*2] |-> PORT_A_PINS_OE == 8'h00 && PORT_A_PINS_OUT == 8'hff)
        else $error("input pins not idle high");

    a_write_no_drive: assert property (
        !req.rd |=> !CPU_DATA_BUS_OE)
        else $error("data bus driven after a write cycle");

    a_read_drives: assert property (
        rd_any |=> CPU_DATA_BUS_OE)
        else $error("selected read got no answer");

    a_port_write_load: assert property (
        wr_pa_data |=> pa_data == $past(req.data))
        else $error("port a latch did not take written data");

    a_count_hold: assert property (
        (!flag && !tick && !tmr_wr) |=> $stable(count))
        else $error("counter moved between intervals");

    a_interval_step: assert property (
        (!flag && tick && !tmr_wr && count != 8'h00) |=> count == $past(count) - 8'h01)
        else $error("counter missed an interval step");

    a_coincident_read: assert property (
        (expire && tmr_rd) |=> flag)
        else $error("read at expiry cleared the flag");

    a_write_clears: assert property (
        tmr_wr |=> !flag)
        else $error("timer write left the flag set");

    a_irq_pin_rest: assert property (
        (!pb_dir[IRQ_PIN_BIT] && !(irq_en && flag))
        |=> PORT_B_PINS_OUT[IRQ_PIN_BIT] && !PORT_B_PINS_OE[IRQ_PIN_BIT])
        else $error("interrupt pin not resting high");
endmodule

// ### src/rrit_pkg.sv
// constants and carrier types for the rom/ram/io/interval-timer block
// assumes a single core clock shared with the processor bus logic
package rrit_pkg;

    localparam int ADDR_W     = 10;
    localparam int DATA_W     = 8;
    localparam int ROM_DEPTH  = 1024;
    localparam int RAM_DEPTH  = 64;
    localparam int RAM_ADDR_W = 6;

    // bit positions on the address bus
    localparam int TIMER_SEL_BIT = 2;
    localparam int IRQ_EN_BIT    = 3;
    localparam int FLAG_SEL_BIT  = 0;

    // port b pins shared with chip selects and the interrupt
    localparam int CS_TWO_BIT  = 5;
    localparam int CS_ONE_BIT  = 6;
    localparam int IRQ_PIN_BIT = 7;

    // register codes on address bits 1..0 when the timer is not selected
    localparam logic [1:0] SEL_PORT_A_DATA = 2'h0;
    localparam logic [1:0] SEL_PORT_A_DIR  = 2'h1;
    localparam logic [1:0] SEL_PORT_B_DATA = 2'h2;
    localparam logic [1:0] SEL_PORT_B_DIR  = 2'h3;

    // prescale codes on address bits 1..0 of a timer write
    localparam logic [1:0] RATE_1T    = 2'h0;
    localparam logic [1:0] RATE_8T    = 2'h1;
    localparam logic [1:0] RATE_64T   = 2'h2;
    localparam logic [1:0] RATE_1024T = 2'h3;

    // last prescaler count for each rate (divide minus one)
    localparam logic [9:0] LAST_1T    = 10'h000;
    localparam logic [9:0] LAST_8T    = 10'h007;
    localparam logic [9:0] LAST_64T   = 10'h03f;
    localparam logic [9:0] LAST_1024T = 10'h3ff;

    // values after reset
    localparam logic [7:0] PORT_DATA_RESET = 8'h00;
    localparam logic [7:0] PORT_DIR_RESET  = 8'h00;
    localparam logic [7:0] PIN_OUT_RESET   = 8'hff;
    localparam logic [7:0] PIN_OE_RESET    = 8'h00;
    localparam logic [7:0] COUNT_RESET     = 8'h00;
    localparam logic [7:0] BUS_DATA_RESET  = 8'h00;
    localparam logic [9:0] PRESCALE_RESET  = 10'h000;
    localparam logic [1:0] RATE_RESET      = 2'h0;

    // build-time options, defaults
    localparam logic [3:0] RAM_CODE_DEFAULT = 4'h0;
    localparam logic [3:0] IO_CODE_DEFAULT  = 4'h8;

    typedef enum logic [0:0] {
        TMR_COUNTING = 1'b0,
        TMR_EXPIRED  = 1'b1
    } rrit_tmr_state_type;

    typedef struct packed {
        logic [9:0] addr;
        logic       rs;
        logic       rd;
        logic [7:0] data;
    } rrit_bus_req_type;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } rrit_pins_type;

endpackage

// ### src/rrit_prescale.sv
// prescaler for the interval timer: one tick per 1, 8, 64 or 1024 clocks
// assumes restart is a one-cycle pulse from the timer write decode
`timescale 1ns/1ps
module rrit_prescale
    import rrit_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // control
    input  wire logic       restart,
    input  wire logic [1:0] rate_in,
    // result
    output logic            tick
);
    logic [9:0] cnt;
    logic [1:0] rate;
    logic [9:0] last;

    assign last = (rate == RATE_1T)  ? LAST_1T  :
                  (rate == RATE_8T)  ? LAST_8T  :
                  (rate == RATE_64T) ? LAST_64T : LAST_1024T;
    assign tick = (cnt == last);

    // first tick lands on the clock right after the write, then every period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= PRESCALE_RESET;
            rate <= RATE_RESET;
        end else if (restart) begin
            rate <= rate_in;
            cnt  <= (rate_in == RATE_1T)  ? LAST_1T  :
                    (rate_in == RATE_8T)  ? LAST_8T  :
                    (rate_in == RATE_64T) ? LAST_64T : LAST_1024T;
        end else begin
            cnt <= tick ? PRESCALE_RESET : cnt + 10'h001;
        end
    end
endmodule

// ### src/rrit_io_port.sv
// one 8-bit peripheral port: data and direction registers, pin sync, pin drive
// assumes pins arrive asynchronously; outputs are registered one clock late
`timescale 1ns/1ps
module rrit_io_port
    import rrit_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // register writes
    input  wire logic       wr_data,
    input  wire logic       wr_dir,
    input  wire logic [7:0] wr_val,
    // pin overrides
    input  wire logic [7:0] hold_off,
    input  wire logic [7:0] force_low,
    // pins
    input  wire logic [7:0] pins_in,
    output rrit_pins_type   pins,
    // state
    output logic [7:0]      data,
    output logic [7:0]      dir,
    output logic [7:0]      view
);
    logic [7:0] meta;
    logic [7:0] sync;
    logic [7:0] next_out;
    logic [7:0] next_oe;

    assign view = (dir & data) | (~dir & sync);
    // direction per pin; input bits idle high
    assign next_out = ~force_low & (~dir | data);
    assign next_oe  = ~hold_off & (dir | force_low);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= PORT_DATA_RESET;
            sync <= PORT_DATA_RESET;
        end else begin
            meta <= pins_in;
            sync <= meta;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data     <= PORT_DATA_RESET;
            dir      <= PORT_DIR_RESET;
            pins.out <= PIN_OUT_RESET;
            pins.oe  <= PIN_OE_RESET;
        end else begin
            if (wr_data) data <= wr_val;
            if (wr_dir) dir <= wr_val;
            pins.out <= next_out;
            pins.oe  <= next_oe;
        end
    end
endmodule

// ### testbench/rrit_pin_model.sv
// peripheral-side model of one port: external drivers resolved with pull-ups
// assumes the bench never drives a pin while the block drives it
`timescale 1ns/1ps
module rrit_pin_model (
    // from the block
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    // external device
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_oe,
    // resolved level
    output logic      [7:0] pins
);
    // any driver wins over the pull-up
    // an undriven pin settles high, never at a simulator-chosen level
    assign pins = (oe & out) | (~oe & ext_oe & ext_val) | (~oe & ~ext_oe);
endmodule

// ### testbench/testbench.sv
// self-checking bench for the rom, ram, port and interval timer block
// assumes default build options: no chip selects, ram code 0, io code 8
`timescale 1ns/1ps
module testbench
    import rrit_pkg::*;
;
    localparam logic [3:0] IO = IO_CODE_DEFAULT;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    rrit_bus_req_type req = '{10'h3c0, 1'b0, 1'b1, 8'h00};
    logic [7:0]       dout, a_out, a_oe, b_out, b_oe, a_pins, b_pins;
    logic             doe, pull, p;
    logic [7:0]       a_ext = 8'h00, b_ext = 8'h00, a_xoe = 8'h00, b_xoe = 8'h00;
    logic [7:0]       dir, dat, ext, t, d;
    logic [7:0]       ram_a [4];
    logic [7:0]       ram_d [4];
    logic [9:0]       ra;
    logic [31:0]      seed = 32'hec4a;
    int               n;
    int               miscompares = 0;
    int               checked = 0;

    always #20 clk = ~clk;

    rrit_top DUT (
        .CORE_CLK(clk), .NRST(nrst),
        .ADDR(req.addr), .REGION_SELECT(req.rs), .READ_NOT_WRITE(req.rd),
        .CPU_DATA_BUS_IN(req.data), .CPU_DATA_BUS_OUT(dout), .CPU_DATA_BUS_OE(doe),
        .PORT_A_PINS_IN(a_pins), .PORT_A_PINS_OUT(a_out), .PORT_A_PINS_OE(a_oe),
        .PORT_B_PINS_IN(b_pins), .PORT_B_PINS_OUT(b_out), .PORT_B_PINS_OE(b_oe),
        .PORT_B_BIT_SEVEN_PULLUP(pull)
    );
    rrit_pin_model pm_a (.out(a_out), .oe(a_oe), .ext_val(a_ext), .ext_oe(a_xoe), .pins(a_pins));
    rrit_pin_model pm_b (.out(b_out), .oe(b_oe), .ext_val(b_ext), .ext_oe(b_xoe), .pins(b_pins));

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed[7:0] ^ seed[23:16];
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // request held one cycle, taken at the following edge
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{a, 1'b0, 1'b0, v};
        @(posedge clk);
        req <= '{10'h3c0, 1'b0, 1'b1, 8'h00};
        #1;
        chk("bus oe on write", 8'h00, {7'h0, doe});
    endtask

    task automatic rd(input logic [9:0] a, input logic rs, input logic sel,
                      input logic [7:0] exp, input string what);
        @(posedge clk);
        req <= '{a, rs, 1'b1, 8'h00};
        @(posedge clk);
        req <= '{10'h3c0, 1'b0, 1'b1, 8'h00};
        #1;
        chk({what, " oe"}, {7'h0, sel}, {7'h0, doe});
        if (sel) begin
            chk(what, exp, dout);
        end
    endtask

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("pin oe a", PIN_OE_RESET, a_oe);
        chk("pin out b", PIN_OUT_RESET, b_out);
        chk("bus oe", 8'h00, {7'h0, doe});
        chk("bit seven pullup", 8'h01, {7'h0, pull});
        rd({IO, 6'h03}, 1'b0, 1'b1, PORT_DIR_RESET, "dir b");
        rd({IO, 6'h00}, 1'b0, 1'b1, 8'hff, "idle pins a");
        // random port traffic, all-input and all-output first
        for (int i = 0; i < 8; i++) begin
            p = i[0];
            dir = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : rnd();
            dat = rnd();
            ext = rnd();
            if (p) begin
                b_ext <= ext;
                b_xoe <= ~dir;
            end else begin
                a_ext <= ext;
                a_xoe <= ~dir;
            end
            wr({IO, 4'h0, p, 1'b1}, dir);
            wr({IO, 4'h0, p, 1'b0}, dat);
            repeat (3) @(posedge clk);
            rd({IO, 4'h0, p, 1'b0}, 1'b0, 1'b1, (dir & dat) | (~dir & ext), "port");
            rd({IO, 4'h0, p, 1'b0}, 1'b0, 1'b1, (dir & dat) | (~dir & ext), "reread");
            rd({IO, 4'h0, p, 1'b1}, 1'b0, 1'b1, dir, "dir");
            chk("pin oe", dir, p ? b_oe : a_oe);
            chk("pin out", dat | ~dir, p ? b_out : a_out);
        end
        for (int i = 0; i < 4; i++) begin
            t = rnd();
            ram_a[i] = {2'h0, i[1:0], t[3:0]};
            ram_d[i] = rnd();
            wr({RAM_CODE_DEFAULT, ram_a[i][5:0]}, ram_d[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd({RAM_CODE_DEFAULT, ram_a[i][5:0]}, 1'b0, 1'b1, ram_d[i], "ram");
            t = rnd();
            ra = (i == 0) ? 10'h3ff : {t[1:0], rnd()};
            rd(ra, 1'b1, 1'b1, ra[7:0] ^ {ra[9:8], 6'h00}, "rom");
        end
        rd({4'h5, 6'h00}, 1'b0, 1'b0, 8'h00, "unselected");
        b_xoe <= 8'h00;
        wr({IO, 6'h03}, 8'h00);
        for (int r = 0; r < 4; r++) begin
            t = rnd();
            d = 8'h02 + {5'h0, t[2:0]};
            n = (r == 0) ? 1 : (r == 1) ? 8 : (r == 2) ? 64 : 1024;
            wr({IO, 4'h3, r[1:0]}, d);
            repeat (n * d - 1) @(posedge clk);
            rd({IO, 6'h0c}, 1'b0, 1'b1, 8'h00, "count at zero");
            rd({IO, 6'h05}, 1'b0, 1'b1, 8'h80, "flag kept");
            chk("irq pin low", 8'h00, {7'h0, b_out[7]});
            chk("irq pin driven", 8'h01, {7'h0, b_oe[7]});
            rd({IO, 6'h04}, 1'b0, 1'b1, 8'hfc, "count after");
            rd({IO, 6'h05}, 1'b0, 1'b1, 8'h00, "flag cleared");
            chk("irq released", 8'h00, {7'h0, b_oe[7]});
        end
        // reset mid-run with interrupt pending and port a driving
        wr({IO, 6'h0c}, 8'h01);
        wr({IO, 6'h01}, 8'hff);
        @(posedge clk);
        #1;
        chk("irq before reset", 8'h01, {7'h0, b_oe[7]});
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("pin oe a again", PIN_OE_RESET, a_oe);
        rd({IO, 6'h01}, 1'b0, 1'b1, PORT_DIR_RESET, "dir a again");
        chk("irq after reset", 8'h00, {7'h0, b_oe[7]});
        tally_and_finish();
    end
endmodule
